// ### hdl/dee_map.svh
`ifndef DEE_MAP_SVH
`define DEE_MAP_SVH
`define DEE_CLK_HZ    25000000
`define DEE_ERASE_US  5000
`define DEE_WRITE_US  5000
`define DEE_CMD_PAGE1 8'h01
`define DEE_CMD_PAGE0 8'h09
`define DEE_REG_CFG   4'h0
`define DEE_REG_STAT  4'h4
`define DEE_REG_CNT   4'h8
`define DEE_CFG_RST   1'h0
`endif

// ### hdl/dee_pkg.sv
package dee_pkg;
  typedef enum logic [2:0] {
    L_IDLE, L_CTRL, L_CACK, L_WDATA, L_WACK, L_RDATA, L_RACK
  } dee_link_t;
  typedef enum logic [1:0] {P_IDLE, P_ERASE, P_WRITE} dee_prog_t;
  typedef struct packed {
    logic [4:0] row;
    logic       byte_order_mode_high;
    logic       byte_order_mode_low;
    logic       transfer_direction_bit;
  } dee_ctrl_t;
endpackage

// ### hdl/dee_sync.sv
module dee_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ### hdl/dee_cond.sv
module dee_cond (
  input  wire logic sda_in,
  input  wire logic scl_in,
  input  wire logic rst,
  output logic      start_tog,
  output logic      stop_tog
);
  // data edges clock these flags; the serial clock level qualifies them
  always_ff @(negedge sda_in or posedge rst) begin
    if (rst) begin
      start_tog <= 1'b0;
    end else if (scl_in) begin
      start_tog <= ~start_tog;
    end
  end

  always_ff @(posedge sda_in or posedge rst) begin
    if (rst) begin
      stop_tog <= 1'b0;
    end else if (scl_in) begin
      stop_tog <= ~stop_tog;
    end
  end
endmodule

// ### hdl/dee_eeprom_link.sv
// Local design decisions: the placing of the registers and the strobed register port.
`include "dee_map.svh"

module dee_eeprom_link
  import dee_pkg::*;
#(
  parameter int unsigned ERASE_CYC = `DEE_ERASE_US * (`DEE_CLK_HZ / 1000000),
  parameter int unsigned WRITE_CYC = `DEE_WRITE_US * (`DEE_CLK_HZ / 1000000)
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       serial_clk,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe
);
  // ---------------- link side, on the serial clock ----------------
  logic        rst_l;
  logic        start_tog;
  logic        stop_tog;
  logic        start_seen;
  logic        start_now;
  logic        busy_l;
  logic        ack_s;
  logic        ack_seen;
  dee_link_t   state;
  dee_ctrl_t   ctrl;
  logic [2:0]  bitcnt;
  logic [7:0]  shreg;
  logic [7:0]  rx_byte;
  logic [7:0]  txsh;
  logic [15:0] buf_w;
  logic [4:0]  fetch_row;
  logic [4:0]  next_row;
  logic [7:0]  first_byte;
  logic [7:0]  second_byte;
  logic        byte_idx;
  logic        ack_ok;
  logic        wr_valid;
  logic        fetch_tog;
  logic        low_sel;

  // ---------------- system side ----------------
  logic        fetch_s;
  logic        fetch_prev;
  logic        fetch_ev;
  logic        stop_s;
  logic        stop_prev;
  logic        stop_ev;
  logic        wrv_s;
  logic        ack_tog;
  logic [15:0] word_q;
  logic        page;
  logic        busy;
  dee_prog_t   pstate;
  logic [17:0] pcnt;
  logic [5:0]  prog_addr;
  logic [15:0] prog_word;
  logic [7:0]  done_cnt;
  logic [15:0] mem [0:63];

  assign sda_out = 1'b0;

  dee_sync u_rst_l (
    .clk (serial_clk),
    .rst (1'b0),
    .d   (rst),
    .q   (rst_l)
  );

  dee_cond u_cond (
    .sda_in    (sda_in),
    .scl_in    (serial_clk),
    .rst       (rst),
    .start_tog (start_tog),
    .stop_tog  (stop_tog)
  );

  dee_sync u_busy_l (
    .clk (serial_clk),
    .rst (rst_l),
    .d   (busy),
    .q   (busy_l)
  );

  dee_sync u_ack_l (
    .clk (serial_clk),
    .rst (rst_l),
    .d   (ack_tog),
    .q   (ack_s)
  );

  // the start flag toggles a full serial period before the first rising bit edge,
  // so protocol ordering, not a synchroniser, makes it safe to read here
  assign start_now   = start_tog != start_seen;
  assign rx_byte     = {shreg[6:0], sda_in};
  assign next_row    = ctrl.byte_order_mode_high ? fetch_row - 5'h01
                                                 : fetch_row + 5'h01;
  assign first_byte  = ctrl.byte_order_mode_low ? buf_w[7:0] : buf_w[15:8];
  assign second_byte = ctrl.byte_order_mode_low ? buf_w[15:8] : buf_w[7:0];
  assign low_sel     = ctrl.byte_order_mode_low ^ byte_idx;

  always_ff @(posedge serial_clk) begin
    if (rst_l) begin
      start_seen <= 1'b0;
    end else begin
      start_seen <= start_tog;
    end
  end

  always_ff @(posedge serial_clk) begin
    if (rst_l) begin
      state <= L_IDLE;
    end else if (start_now) begin
      state <= L_CTRL;
    end else begin
      case (state)
        L_CTRL: begin
          if (bitcnt == 3'h7) state <= L_CACK;
        end
        L_CACK: begin
          if (!ack_ok) state <= L_IDLE;
          // page commands carry no data; sending here would pin the line and block the stop
          else if (ctrl == `DEE_CMD_PAGE1 || ctrl == `DEE_CMD_PAGE0) state <= L_IDLE;
          else if (ctrl.transfer_direction_bit) state <= L_RDATA;
          else state <= L_WDATA;
        end
        L_WDATA: begin
          if (bitcnt == 3'h7) state <= L_WACK;
        end
        L_WACK: begin
          // only one or two data bytes per write
          state <= byte_idx ? L_WDATA : L_IDLE;
        end
        L_RDATA: begin
          if (bitcnt == 3'h7) state <= L_RACK;
        end
        L_RACK: begin
          state <= sda_in ? L_IDLE : L_RDATA;
        end
        default: begin
          state <= L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge serial_clk) begin
    if (rst_l) begin
      bitcnt <= 3'h0;
    end else if (start_now) begin
      bitcnt <= 3'h1;
    end else if (state == L_CTRL || state == L_WDATA || state == L_RDATA) begin
      bitcnt <= bitcnt + 3'h1;
    end else begin
      bitcnt <= 3'h0;
    end
  end

  always_ff @(posedge serial_clk) begin
    if (rst_l) begin
      shreg <= 8'h00;
    end else begin
      shreg <= rx_byte;
    end
  end

  always_ff @(posedge serial_clk) begin
    if (rst_l) begin
      ctrl   <= '0;
      ack_ok <= 1'b0;
    end else if (state == L_CTRL && bitcnt == 3'h7 && !start_now) begin
      ctrl   <= dee_ctrl_t'(rx_byte);
      ack_ok <= !busy_l;
    end
  end

  // the row is complete after five bits, which leaves time to fetch the word
  always_ff @(posedge serial_clk) begin
    if (rst_l) begin
      fetch_row <= 5'h00;
      fetch_tog <= 1'b0;
    end else if (start_now) begin
      fetch_row <= fetch_row;
    end else if (state == L_CTRL && bitcnt == 3'h4) begin
      fetch_row <= rx_byte[4:0];
      fetch_tog <= ~fetch_tog;
    end else if (state == L_RACK && !sda_in && byte_idx) begin
      fetch_row <= next_row;
      fetch_tog <= ~fetch_tog;
    end
  end

  always_ff @(posedge serial_clk) begin
    if (rst_l) begin
      ack_seen <= 1'b0;
    end else begin
      ack_seen <= ack_s;
    end
  end

  always_ff @(posedge serial_clk) begin
    if (rst_l) begin
      buf_w <= 16'h0000;
    end else if (ack_s != ack_seen) begin
      buf_w <= word_q;
    end else if (state == L_WDATA && bitcnt == 3'h7 && !start_now) begin
      if (low_sel) buf_w[7:0] <= rx_byte;
      else buf_w[15:8] <= rx_byte;
    end
  end

  always_ff @(posedge serial_clk) begin
    if (rst_l || start_now) begin
      byte_idx <= 1'b0;
    end else if ((state == L_WDATA || state == L_RDATA) && bitcnt == 3'h7) begin
      byte_idx <= ~byte_idx;
    end
  end

  always_ff @(posedge serial_clk) begin
    if (rst_l || start_now) begin
      wr_valid <= 1'b0;
    end else if (state == L_WDATA && bitcnt == 3'h7) begin
      wr_valid <= 1'b1;
    end
  end

  always_ff @(posedge serial_clk) begin
    if (rst_l) begin
      txsh <= 8'h00;
    end else if (state == L_CACK) begin
      txsh <= first_byte;
    end else if (state == L_RDATA) begin
      txsh <= {txsh[6:0], 1'b0};
    end else if (state == L_RACK) begin
      txsh <= byte_idx ? second_byte : first_byte;
    end
  end

  // the pin moves only on the falling serial edge, while the clock is low
  always_ff @(negedge serial_clk) begin
    if (rst_l) begin
      sda_oe <= 1'b0;
    end else begin
      case (state)
        L_CACK:  sda_oe <= ack_ok;
        L_WACK:  sda_oe <= 1'b1;
        L_RDATA: sda_oe <= !txsh[7];
        default: sda_oe <= 1'b0;
      endcase
    end
  end

  // ---------------- system clock domain ----------------
  dee_sync u_fetch_s (
    .clk (clock),
    .rst (rst),
    .d   (fetch_tog),
    .q   (fetch_s)
  );

  dee_sync u_stop_s (
    .clk (clock),
    .rst (rst),
    .d   (stop_tog),
    .q   (stop_s)
  );

  dee_sync u_wrv_s (
    .clk (clock),
    .rst (rst),
    .d   (wr_valid),
    .q   (wrv_s)
  );

  assign fetch_ev = fetch_s != fetch_prev;
  assign stop_ev  = stop_s != stop_prev;
  assign busy     = pstate != P_IDLE;

  always_ff @(posedge clock) begin
    if (rst) begin
      fetch_prev <= 1'b0;
      stop_prev  <= 1'b0;
    end else begin
      fetch_prev <= fetch_s;
      stop_prev  <= stop_s;
    end
  end

  // word and toggle change together; the two-flop delay covers the word
  always_ff @(posedge clock) begin
    if (rst) begin
      word_q  <= 16'h0000;
      ack_tog <= 1'b0;
    end else if (fetch_ev) begin
      word_q  <= mem[{page, fetch_row}];
      ack_tog <= ~ack_tog;
    end
  end

  // at a stop the serial clock has halted, so link registers hold still
  always_ff @(posedge clock) begin
    if (rst) begin
      pstate    <= P_IDLE;
      pcnt      <= 18'h00000;
      prog_addr <= 6'h00;
      prog_word <= 16'h0000;
    end else begin
      case (pstate)
        P_IDLE: begin
          if (stop_ev && wrv_s) begin
            pstate    <= P_ERASE;
            pcnt      <= 18'h00000;
            prog_addr <= {page, fetch_row};
            prog_word <= buf_w;
          end
        end
        P_ERASE: begin
          if (pcnt == 18'(ERASE_CYC - 1)) begin
            pstate <= P_WRITE;
            pcnt   <= 18'h00000;
          end else begin
            pcnt <= pcnt + 18'h00001;
          end
        end
        P_WRITE: begin
          if (pcnt == 18'(WRITE_CYC - 1)) pstate <= P_IDLE;
          else pcnt <= pcnt + 18'h00001;
        end
        default: begin
          pstate <= P_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (pstate == P_ERASE && pcnt == 18'(ERASE_CYC - 1)) begin
      mem[prog_addr] <= 16'h0000;
    end else if (pstate == P_WRITE && pcnt == 18'(WRITE_CYC - 1)) begin
      mem[prog_addr] <= prog_word;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      done_cnt <= 8'h00;
    end else if (pstate == P_WRITE && pcnt == 18'(WRITE_CYC - 1)) begin
      done_cnt <= done_cnt + 8'h01;
    end
  end

  // software write and page command share the bit; software wins a tie
  always_ff @(posedge clock) begin
    if (rst) begin
      page <= `DEE_CFG_RST;
    end else if (wr && addr == `DEE_REG_CFG) begin
      page <= wdata[0];
    end else if (!busy && stop_ev && !wrv_s && ack_ok) begin
      if (ctrl == `DEE_CMD_PAGE1) page <= 1'b1;
      else if (ctrl == `DEE_CMD_PAGE0) page <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `DEE_REG_CFG:  rdata <= {7'h00, page};
        `DEE_REG_STAT: rdata <= {5'h00, pstate == P_WRITE, pstate == P_ERASE, busy};
        `DEE_REG_CNT:  rdata <= done_cnt;
        default:       rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ---------------- checks ----------------
  a_start_ctrl: assert property (@(posedge serial_clk) disable iff (rst_l)
    start_now |=> state == L_CTRL) else $error("start not taken");

  a_ctrl_nack: assert property (@(posedge serial_clk) disable iff (rst_l)
    (state == L_CTRL && bitcnt == 3'h7 && busy_l && !start_now)
    |=> (state == L_CACK && !ack_ok) ##1 !sda_oe) else $error("acked while busy");

  a_ack_drive: assert property (@(posedge serial_clk) disable iff (rst_l)
    (state == L_CACK && ack_ok) |-> sda_oe) else $error("ack not driven");

  a_nack_stops: assert property (@(posedge serial_clk) disable iff (rst_l)
    (state == L_RACK && sda_in && !start_now) |=> state == L_IDLE)
    else $error("sent after nack");

  a_idle_float: assert property (@(posedge serial_clk) disable iff (rst_l)
    (state == L_IDLE && $past(state) == L_IDLE) |-> !sda_oe)
    else $error("line driven in standby");

  a_row_msb: assert property (@(posedge serial_clk) disable iff (rst_l)
    (state == L_CTRL && bitcnt == 3'h7 && !start_now) |=> ctrl.row == fetch_row)
    else $error("row bits misplaced");

  a_row_step: assert property (@(posedge serial_clk) disable iff (rst_l)
    (state == L_RACK && !sda_in && byte_idx && !start_now && !ctrl.byte_order_mode_high)
    |=> fetch_row == $past(fetch_row) + 5'h01) else $error("row not advanced");

  a_prog_start: assert property (@(posedge clock) disable iff (rst)
    (pstate == P_IDLE && stop_ev && wrv_s) |=> pstate == P_ERASE ##1 busy)
    else $error("write cycle not started");

  a_erase_write: assert property (@(posedge clock) disable iff (rst)
    (pstate == P_ERASE && pcnt == 18'(ERASE_CYC - 1))
    |=> (pstate == P_WRITE && pcnt == 18'h00000)) else $error("phase order");

  a_commit_word: assert property (@(posedge clock) disable iff (rst)
    (pstate == P_WRITE && pcnt == 18'(WRITE_CYC - 1))
    |=> (mem[prog_addr] == prog_word && pstate == P_IDLE)) else $error("word lost");

  a_fetch_ack: assert property (@(posedge clock) disable iff (rst)
    fetch_ev |=> ack_tog != $past(ack_tog)) else $error("fetch not answered");

  c_read_two: cover property (@(posedge serial_clk) disable iff (rst_l)
    state == L_RACK && !sda_in && byte_idx);
  c_busy_nack: cover property (@(posedge serial_clk) disable iff (rst_l)
    state == L_CACK && !ack_ok);
  c_commit: cover property (@(posedge clock) disable iff (rst)
    pstate == P_WRITE ##1 pstate == P_IDLE);
endmodule

// ### verif/dee_mstr.sv
module dee_mstr (
  output logic      serial_clk,
  output logic      m_low,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 10ps;

  // the clock rests high between frames; pulses with data released are harmless
  initial begin
    serial_clk = 1'b1;
    m_low      = 1'b0;
  end

  task automatic idle_clocks(input int n);
    repeat (n) begin
      serial_clk = 1'b0;
      #62.5 serial_clk = 1'b1;
      #62.5;
    end
  endtask

  task automatic start;
    m_low = 1'b1;
    #62.5 serial_clk = 1'b0;
    #31.25;
  endtask

  task automatic stop;
    m_low = 1'b1;
    #31.25 serial_clk = 1'b1;
    #62.5 m_low = 1'b0;
    #62.5;
  endtask

  // data moves mid low phase; the line is sampled just before the fall
  task automatic bitx(input logic b, output logic s);
    m_low = ~b;
    #31.25 serial_clk = 1'b1;
    #62.5 s = sda_line;
    serial_clk = 1'b0;
    #31.25;
  endtask

  task automatic send8(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(v[i], s);
    end
    bitx(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv8(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      v[i] = s;
    end
    bitx(last, s);
  endtask
endmodule

// ### verif/test_dee_eeprom_link.sv
module test_dee_eeprom_link;
  import dee_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned ERASE_CYC = 20;
  localparam int unsigned WRITE_CYC = 20;

  logic        clock = 1'b0;
  logic        rst;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [3:0]  addr  = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        serial_clk;
  logic        m_low;
  logic        sda_out;
  logic        sda_oe;
  logic        sda_line;
  logic [7:0]  v;
  logic [31:0] q;
  int          fail_count = 0;
  int          cmp_count  = 0;

  // open drain with pull-up: either party pulling low wins
  assign sda_line = ~sda_oe & ~m_low;

  always #20 clock = ~clock;

  dee_eeprom_link #(.ERASE_CYC(ERASE_CYC), .WRITE_CYC(WRITE_CYC)) dee_eeprom_link_inst (
    .clock      (clock),
    .rst        (rst),
    .addr       (addr),
    .wdata      (wdata),
    .wr         (wr),
    .rd         (rd),
    .rdata      (rdata),
    .serial_clk (serial_clk),
    .sda_in     (sda_line),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe)
  );

  dee_mstr dee_mstr_inst (
    .serial_clk (serial_clk),
    .m_low      (m_low),
    .sda_line   (sda_line)
  );

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [7:0] ctl(input logic [4:0] r, input logic h, input logic l,
                                     input logic d);
    return {r, h, l, d};
  endfunction

  // back-to-back status reads, counting cycles spent in each phase
  task automatic wait_prog(output int e, output int w);
    logic       seen;
    logic [7:0] s;
    seen = 1'b0;
    e    = 0;
    w    = 0;
    @(posedge clock);
    addr <= 4'h4;
    rd   <= 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(posedge clock);
      #1 s = rdata;
      if (s[2] && e == 0) begin
        e = -1000;
      end
      e += s[1];
      w += s[2];
      if (seen && !s[0]) begin
        break;
      end
      seen |= s[0];
      if (i == 399) begin
        check("programming finished", 1, 0);
        test_done();
      end
    end
    @(posedge clock);
    rd <= 1'b0;
  endtask

  task automatic ee_write(input logic [7:0] c, input int n, input logic [15:0] d,
                          input logic poll);
    logic a;
    int   e;
    int   w;
    dee_mstr_inst.start();
    dee_mstr_inst.send8(c, a);
    check("control ack", 1, a);
    for (int i = 0; i < n; i++) begin
      dee_mstr_inst.send8(i == 0 ? d[15:8] : d[7:0], a);
      check("data ack", 1, a);
    end
    dee_mstr_inst.stop();
    check("standby release", 0, sda_oe);
    fork
      wait_prog(e, w);
      if (poll) begin
        dee_mstr_inst.start();
        dee_mstr_inst.send8(c, a);
        check("busy poll ack", 0, a);
        dee_mstr_inst.stop();
      end
    join
    check("erase cycles", ERASE_CYC, e);
    check("write cycles", WRITE_CYC, w);
  endtask

  task automatic ee_read(input logic [7:0] c, input int n, output logic [31:0] r);
    logic a;
    r = 32'h0;
    dee_mstr_inst.start();
    dee_mstr_inst.send8(c, a);
    check("read control ack", 1, a);
    for (int i = 0; i < n; i++) begin
      dee_mstr_inst.recv8(i == n - 1, r[8 * (3 - i) +: 8]);
    end
    check("release after nack", 0, sda_oe);
    dee_mstr_inst.stop();
    check("standby release", 0, sda_oe);
  endtask

  task automatic page_cmd(input logic [7:0] c, input logic [7:0] exp);
    logic a;
    dee_mstr_inst.start();
    dee_mstr_inst.send8(c, a);
    check("page command ack", 1, a);
    dee_mstr_inst.stop();
    // the stop crosses two synchroniser stages before the page bit moves
    repeat (4) @(posedge clock);
    reg_rd(4'h0, v);
    check("page select", exp, v);
  endtask

  initial begin
    #3000000;
    check("watchdog", 1, 0);
    test_done();
  end

  initial begin
    // assigned, not initialised, so the data-edge flags see a reset edge
    rst <= 1'b1;
    // the link side resets from serial clock edges, so pulse it inside and after reset;
    // the short delay lets the partner's resting clock level settle first
    fork
      #1 dee_mstr_inst.idle_clocks(3);
      begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
      end
    join
    dee_mstr_inst.idle_clocks(3);
    check("idle release", 0, sda_oe);
    check("open drain level", 0, sda_out);
    reg_rd(4'h0, v);
    check("cfg reset", 8'h00, v);
    reg_rd(4'h4, v);
    check("stat reset", 8'h00, v);
    reg_rd(4'h8, v);
    check("count reset", 8'h00, v);
    reg_wr(4'h0, 8'h01);
    reg_wr(4'hc, 8'hff);
    reg_rd(4'h0, v);
    check("cfg write", 8'h01, v);
    reg_rd(4'hc, v);
    check("unmapped read", 8'h00, v);
    reg_wr(4'h0, 8'h00);
    $display("done: registers");

    page_cmd(8'h01, 8'h01);
    page_cmd(8'h09, 8'h00);
    $display("done: page commands");

    ee_write(ctl(5'd5, 1'b0, 1'b0, 1'b0), 2, 16'ha53c, 1'b1);
    ee_read(ctl(5'd5, 1'b0, 1'b0, 1'b1), 2, q);
    check("high first word", 16'ha53c, q[31:16]);
    ee_write(ctl(5'd5, 1'b0, 1'b1, 1'b0), 1, 16'h7700, 1'b0);
    ee_read(ctl(5'd5, 1'b0, 1'b1, 1'b1), 2, q);
    check("low byte replaced", 16'h77a5, q[31:16]);
    $display("done: write and read");

    page_cmd(8'h01, 8'h01);
    ee_write(ctl(5'd5, 1'b0, 1'b0, 1'b0), 2, 16'h1234, 1'b0);
    ee_read(ctl(5'd5, 1'b0, 1'b0, 1'b1), 2, q);
    check("page1 word", 16'h1234, q[31:16]);
    page_cmd(8'h09, 8'h00);
    ee_read(ctl(5'd5, 1'b0, 1'b0, 1'b1), 2, q);
    check("page0 word kept", 16'ha577, q[31:16]);
    $display("done: two pages");

    ee_write(ctl(5'd31, 1'b0, 1'b0, 1'b0), 2, 16'hbeef, 1'b0);
    ee_write(ctl(5'd0, 1'b0, 1'b0, 1'b0), 2, 16'hcafe, 1'b0);
    ee_read(ctl(5'd31, 1'b0, 1'b0, 1'b1), 4, q);
    check("increment wrap", 32'hbeefcafe, q);
    ee_read(ctl(5'd0, 1'b1, 1'b1, 1'b1), 4, q);
    check("decrement wrap", 32'hfecaefbe, q);
    // 01h is the page command, so this read sets the decrement bit instead
    ee_read(ctl(5'd0, 1'b1, 1'b0, 1'b1), 1, q);
    check("single byte read", 8'hca, q[31:24]);
    reg_rd(4'h8, v);
    check("programming count", 8'h05, v);
    $display("done: sequential reads");
    test_done();
  end
endmodule
